// ==== bridge_fwd_defs.vh ====
// Constants shared by the transaction forwarding core and its test bench
`ifndef BRIDGE_FWD_DEFS_VH
`define BRIDGE_FWD_DEFS_VH

// ----------------------------------------------------------------------
// Port numbering
// ----------------------------------------------------------------------
`define PORT_PRI      2'd0
`define PORT_SEC_ONE  2'd1
`define PORT_SEC_TWO  2'd2
`define PORT_NONE     2'd3

// ----------------------------------------------------------------------
// Bus commands
// ----------------------------------------------------------------------
`define CMD_MEM_WR    4'h7
`define CMD_MEM_WR_INV 4'hf
`define CMD_WR_BIT    0

// ----------------------------------------------------------------------
// Queue entry layout {dest, cmd, addr, data}
// ----------------------------------------------------------------------
`define ENT_DATA_LSB  0
`define ENT_ADDR_LSB  32
`define ENT_CMD_LSB   64
`define ENT_DEST_LSB  68
`define ENT_WIDTH     70
`define POSTED_DEPTH  16

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define MA_WAIT_NS    50
`define MA_WAIT_CYC   ((`MA_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Reset and master-abort values
// ----------------------------------------------------------------------
`define ABORT_RDATA   32'hffffffff
`define STROBES_IDLE  3'h7

`endif

// ==== posted_fifo.v ====
// First-in first-out queue holding posted writes
`timescale 1ns/100ps
`default_nettype none

module posted_fifo #(
  parameter WIDTH = 70,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             clk,
  input  wire             reset_n,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  // Occupancy
  output wire [AW:0]      count
);

  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr_ff;
  reg  [AW-1:0]    rd_ptr_ff;
  reg  [AW:0]      cnt_ff;
  wire             push;
  wire             pop;

  assign in_ready  = (cnt_ff != DEPTH[AW:0]);
  assign out_valid = (cnt_ff != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr_ff];
  assign count     = cnt_ff;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_ff] <= in_data;
  end

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      cnt_ff    <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop)
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      if (push && !pop)
        cnt_ff <= cnt_ff + 1'b1;
      else if (pop && !push)
        cnt_ff <= cnt_ff - 1'b1;
    end
  end

endmodule

`default_nettype wire

// ==== three_port_forwarding.v ====
// Claiming, ordering and forwarding core of a three-port bus bridge
`timescale 1ns/100ps
`default_nettype none
`include "bridge_fwd_defs.vh"

// Functional notes
// [R1] Primary-local target: primary cycle left unclaimed
// [R2] Primary-to-secondary: claim, post or retry
// [R3] Forward, hold result, finish identical repeat
// [R4] Primary cycle decoding nowhere stays unclaimed
// [R5] Secondary cycle to same/no bus unclaimed
// [R6] Secondary cycle elsewhere: claim, post/retry, forward
// [R7] All forwarding obeys bus ordering constraints
// [R8] Memory write and invalidate are posted
// [R9] Reads become delayed read request/completion
// [R10] Other writes become delayed write request/completion
// [R11] Later transaction judged against each earlier one
// [R12] Posted writes drain strictly in order
// [R13] Delayed read waits for earlier posted writes
// [R14] Posted write passes head delayed request
// [R15] Write completion passes all but completions
// [R16] Requests pass completions; read completions wait writes
// [R17] Master abort: release frame, then initiator-ready
module three_port_forwarding #(
  parameter [31:0] PRI_BASE     = 32'h00000000,
  parameter [31:0] PRI_LIMIT    = 32'h3fffffff,
  parameter [31:0] SEC_ONE_BASE = 32'h40000000,
  parameter [31:0] SEC_ONE_LIMIT = 32'h5fffffff,
  parameter [31:0] SEC_TWO_BASE = 32'h60000000,
  parameter [31:0] SEC_TWO_LIMIT = 32'h7fffffff,
  parameter        DEPTH        = `POSTED_DEPTH,
  parameter        AW           = 4
) (
  // Clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // Initiator cycles, port i in slice i
  input  wire [2:0]  cyc_start,
  input  wire [95:0] cyc_addr,
  input  wire [11:0] cyc_cmd,
  input  wire [95:0] cyc_wdata,
  input  wire        primary_other_devsel_n,
  // Target-side answers
  output wire        primary_device_select_n,
  output wire        secondary_one_device_select_n,
  output wire        secondary_two_device_select_n,
  output wire [2:0]  resp_done,
  output wire [2:0]  resp_retry,
  output wire [31:0] resp_rdata,
  // Forwarding initiator
  output wire [2:0]  mst_frame_n,
  output wire [2:0]  mst_irdy_n,
  output wire [31:0] mst_addr,
  output wire [3:0]  mst_cmd,
  output wire [31:0] mst_wdata,
  input  wire [2:0]  mst_devsel_n,
  input  wire [2:0]  mst_ack,
  input  wire [31:0] mst_rdata
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'b0001, ST_WAIT = 4'b0010, ST_ABT = 4'b0100, ST_DONE = 4'b1000;
  localparam integer MA_CYC_INT = `MA_WAIT_CYC;
  localparam [2:0] MA_CYC  = MA_CYC_INT[2:0];
  reg  [3:0]     state_ff, mcmd_ff, slot_cmd_ff;
  reg  [2:0]     devsel_n_ff, done_ff, retry_ff, frame_n_ff, irdy_n_ff, wait_cnt_ff;
  reg  [31:0]    rdata_ff, maddr_ff, mwdata_ff, slot_addr_ff, slot_wdata_ff, slot_rdata_ff;
  reg  [1:0]     mdest_ff, slot_port_ff, slot_dest_ff;
  reg            mposted_ff, seen_ff, slot_busy_ff, slot_done_ff;
  reg  [AW:0]    slot_ahead_ff, cmpl_ahead_ff;
  wire [5:0]     dst;
  wire [2:0]     claim, posted, match;
  wire [AW:0]    fifo_count;
  wire           fifo_in_ready, fifo_out_valid, pop;
  wire [69:0]    fifo_out_data;
  reg  [1:0]     win;
  reg            win_any;
  integer        i;

  // ----------------------------------------------------------------------
  // Address decode and claim decision per port
  // ----------------------------------------------------------------------
  function [1:0] dest_of;
    input [1:0]  src;
    input [31:0] a;
    reg hit_p, hit_one, hit_two;
    begin
      hit_p   = (a >= PRI_BASE) && (a <= PRI_LIMIT);
      hit_one = (a >= SEC_ONE_BASE) && (a <= SEC_ONE_LIMIT);
      hit_two = (a >= SEC_TWO_BASE) && (a <= SEC_TWO_LIMIT);
      dest_of = `PORT_NONE;
      case (src)
        // Local primary targets and unmapped addresses are left alone
        `PORT_PRI:
          if (!hit_p && hit_one)                                             // R1 R4
            dest_of = `PORT_SEC_ONE;
          else if (!hit_p && hit_two)
            dest_of = `PORT_SEC_TWO;
        `PORT_SEC_ONE:
          if (hit_p)                                                         // R5
            dest_of = `PORT_PRI;
          else if (hit_two)
            dest_of = `PORT_SEC_TWO;
        `PORT_SEC_TWO:
          if (hit_p)                                                         // R5
            dest_of = `PORT_PRI;
          else if (hit_one)
            dest_of = `PORT_SEC_ONE;
        default:
          dest_of = `PORT_NONE;
      endcase
    end
  endfunction
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_port
      localparam integer PIDX = g;
      assign dst[g*2+:2] = dest_of(PIDX[1:0], cyc_addr[g*32+:32]);
      // Fast or medium primary responders already own the cycle
      assign claim[g]  = cyc_start[g] && (dst[g*2+:2] != `PORT_NONE) &&
                         !(g == 0 && !primary_other_devsel_n);               // R1
      assign posted[g] = (cyc_cmd[g*4+:4] == `CMD_MEM_WR) ||
                         (cyc_cmd[g*4+:4] == `CMD_MEM_WR_INV);               // R8
      // Read completions wait until earlier posted writes are gone
      assign match[g]  = slot_done_ff && (slot_port_ff == PIDX[1:0]) &&
                         (slot_addr_ff == cyc_addr[g*32+:32]) &&
                         (slot_cmd_ff == cyc_cmd[g*4+:4]) &&
                         (cyc_cmd[g*4+`CMD_WR_BIT] ||
                          (cmpl_ahead_ff == {(AW+1){1'b0}}));                // R15 R16
    end
  endgenerate
  // Lowest port number wins when several claim at once; the rest retry
  always @*
  begin
    win     = 2'd0;
    win_any = 1'b0;
    for (i = 2; i >= 0; i = i - 1)
      if (claim[i])
      begin
        win     = i[1:0];
        win_any = 1'b1;
      end
  end

  // ----------------------------------------------------------------------
  // Posted write queue
  // ----------------------------------------------------------------------
  wire do_post = win_any && posted[win] && fifo_in_ready;
  wire do_cmpl = win_any && !posted[win] && match[win];
  wire do_cap  = win_any && !posted[win] && !match[win] && !slot_busy_ff;
  assign pop = (state_ff == ST_IDLE) && fifo_out_valid;
  posted_fifo #(.WIDTH (`ENT_WIDTH), .DEPTH (DEPTH), .AW (AW)) u_posted (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (do_post),
    .in_ready  (fifo_in_ready),
    .in_data   ({dst[win*2+:2], cyc_cmd[win*4+:4], cyc_addr[win*32+:32],
                 cyc_wdata[win*32+:32]}),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data),
    .count     (fifo_count)
  );

  // ----------------------------------------------------------------------
  // Target-side answers and delayed transaction slot
  // ----------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      devsel_n_ff   <= `STROBES_IDLE;
      done_ff       <= 3'h0;
      retry_ff      <= 3'h0;
      rdata_ff      <= 32'h00000000;
      slot_busy_ff  <= 1'b0;
      slot_port_ff  <= `PORT_PRI;
      slot_dest_ff  <= `PORT_NONE;
      slot_addr_ff  <= 32'h00000000;
      slot_cmd_ff   <= 4'h0;
      slot_wdata_ff <= 32'h00000000;
      slot_ahead_ff <= {(AW+1){1'b0}};
    end
    else
    begin
      devsel_n_ff <= ~claim;                                                 // R2 R6
      done_ff     <= 3'h0;
      retry_ff    <= claim;
      if (do_post || do_cmpl)
      begin
        // Posted writes end normally; a repeated delayed cycle gets its result
        done_ff[win]  <= 1'b1;                                               // R2 R3 R6
        retry_ff[win] <= 1'b0;
      end
      if (do_cmpl)
      begin
        rdata_ff     <= slot_rdata_ff;                                       // R3
        slot_busy_ff <= 1'b0;
      end
      else if (do_cap)
      begin
        // One delayed request at a time: later requests are retried
        slot_busy_ff  <= 1'b1;                                               // R9 R10 R16
        slot_port_ff  <= win;
        slot_dest_ff  <= dst[win*2+:2];
        slot_addr_ff  <= cyc_addr[win*32+:32];
        slot_cmd_ff   <= cyc_cmd[win*4+:4];
        slot_wdata_ff <= cyc_wdata[win*32+:32];
        slot_ahead_ff <= fifo_count - {{AW{1'b0}}, pop};                     // R13
      end
      else if (pop && slot_ahead_ff != {(AW+1){1'b0}})
        slot_ahead_ff <= slot_ahead_ff - 1'b1;                               // R11
    end
  end

  // ----------------------------------------------------------------------
  // Forwarding initiator
  // ----------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_ff      <= ST_IDLE;
      frame_n_ff    <= `STROBES_IDLE;
      irdy_n_ff     <= `STROBES_IDLE;
      maddr_ff      <= 32'h00000000;
      mcmd_ff       <= 4'h0;
      mwdata_ff     <= 32'h00000000;
      mdest_ff      <= `PORT_PRI;
      mposted_ff    <= 1'b0;
      seen_ff       <= 1'b0;
      wait_cnt_ff   <= 3'h0;
      slot_done_ff  <= 1'b0;
      slot_rdata_ff <= 32'h00000000;
      cmpl_ahead_ff <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_cmpl || do_cap)
        slot_done_ff <= 1'b0;
      if (pop && cmpl_ahead_ff != {(AW+1){1'b0}})
        cmpl_ahead_ff <= cmpl_ahead_ff - 1'b1;                               // R16
      case (state_ff)
        ST_IDLE:
        begin
          seen_ff     <= 1'b0;
          wait_cnt_ff <= 3'h0;
          // Posted writes go first, in order, even past the head request
          if (fifo_out_valid)                                                // R12 R14
          begin
            mdest_ff   <= fifo_out_data[`ENT_DEST_LSB+:2];
            mcmd_ff    <= fifo_out_data[`ENT_CMD_LSB+:4];
            maddr_ff   <= fifo_out_data[`ENT_ADDR_LSB+:32];
            mwdata_ff  <= fifo_out_data[`ENT_DATA_LSB+:32];
            mposted_ff <= 1'b1;
            frame_n_ff[fifo_out_data[`ENT_DEST_LSB+:2]] <= 1'b0;
            irdy_n_ff[fifo_out_data[`ENT_DEST_LSB+:2]]  <= 1'b0;
            state_ff   <= ST_WAIT;
          end
          else if (slot_busy_ff && !slot_done_ff &&
                   slot_ahead_ff == {(AW+1){1'b0}})                          // R13 R7
          begin
            mdest_ff   <= slot_dest_ff;
            mcmd_ff    <= slot_cmd_ff;
            maddr_ff   <= slot_addr_ff;
            mwdata_ff  <= slot_wdata_ff;
            mposted_ff <= 1'b0;
            frame_n_ff[slot_dest_ff] <= 1'b0;
            irdy_n_ff[slot_dest_ff]  <= 1'b0;
            state_ff   <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          if (!mst_devsel_n[mdest_ff])
            seen_ff <= 1'b1;
          if (mst_ack[mdest_ff])
          begin
            frame_n_ff    <= `STROBES_IDLE;
            irdy_n_ff     <= `STROBES_IDLE;
            slot_rdata_ff <= mst_rdata;
            state_ff      <= ST_DONE;
          end
          else if (!seen_ff && mst_devsel_n[mdest_ff])
          begin
            wait_cnt_ff <= wait_cnt_ff + 1'b1;
            if (wait_cnt_ff == MA_CYC - 3'd1)
            begin
              // Nobody answered: frame goes first, initiator-ready a cycle later
              frame_n_ff    <= `STROBES_IDLE;                                // R17
              slot_rdata_ff <= `ABORT_RDATA;
              state_ff      <= ST_ABT;
            end
          end
        end
        ST_ABT:
        begin
          irdy_n_ff <= `STROBES_IDLE;                                        // R17
          state_ff  <= ST_DONE;
        end
        ST_DONE:
        begin
          // Result held for the repeat; read completions queue behind posted writes
          if (!mposted_ff)
          begin
            slot_done_ff  <= 1'b1;                                           // R3 R9 R10
            cmpl_ahead_ff <= fifo_count;                                     // R16
          end
          state_ff <= ST_IDLE;
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign primary_device_select_n       = devsel_n_ff[0];
  assign secondary_one_device_select_n = devsel_n_ff[1];
  assign secondary_two_device_select_n = devsel_n_ff[2];
  assign resp_done   = done_ff;
  assign resp_retry  = retry_ff;
  assign resp_rdata  = rdata_ff;
  assign mst_frame_n = frame_n_ff;
  assign mst_irdy_n  = irdy_n_ff;
  assign mst_addr    = maddr_ff;
  assign mst_cmd     = mcmd_ff;
  assign mst_wdata   = mwdata_ff;

endmodule

`default_nettype wire

// ==== bus_targets.sv ====
// Behavioural targets answering forwarded cycles on the three buses
`timescale 1ns/100ps
`default_nettype none
module bus_targets (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Forwarded cycle
  input  wire logic [2:0]  mst_frame_n,
  input  wire logic [31:0] mst_addr,
  // Target answers
  output var  logic [2:0]  mst_devsel_n,
  output var  logic [2:0]  mst_ack,
  output var  logic [31:0] mst_rdata,
  // Behaviour: silent buses never answer, stall withholds completion
  input  wire logic [2:0]  silent,
  input  wire logic        stall
);
  always @(posedge clk)
  begin
    mst_ack <= 3'h0;
    // Data outside a hand-over must not look valid
    mst_rdata <= ~mst_rdata;
    if (!reset_n)
    begin
      mst_devsel_n <= 3'h7;
      mst_rdata <= 32'h0;
    end
    else
      for (int i = 0; i < 3; i++)
        if (!mst_frame_n[i] && !silent[i] && !mst_ack[i])
        begin
          mst_devsel_n[i] <= 1'b0;
          if (!stall && !mst_devsel_n[i])
          begin
            mst_ack[i] <= 1'b1;
            mst_rdata <= ~mst_addr;
          end
        end
        else
          mst_devsel_n[i] <= 1'b1;
  end
endmodule
`default_nettype wire

// ==== fwd_chk_sva.sv ====
// Port assertions for the forwarding core
`timescale 1ns/100ps
`default_nettype none
module fwd_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // Target side
  input wire logic [2:0]  cyc_start,
  input wire logic [95:0] cyc_addr,
  input wire logic        primary_other_devsel_n,
  input wire logic        primary_device_select_n,
  input wire logic        secondary_one_device_select_n,
  input wire logic [2:0]  resp_done,
  input wire logic [2:0]  resp_retry,
  // Forwarding side
  input wire logic [2:0]  mst_frame_n,
  input wire logic [2:0]  mst_irdy_n,
  input wire logic [2:0]  mst_devsel_n,
  input wire logic [2:0]  mst_ack
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Windows follow the core's default parameters only
  wire [2:0] a0 = cyc_addr[31:29];
  wire [2:0] a1 = cyc_addr[63:61];
  wire       p_loc = a0[2:1] == 2'h0;
  wire       p_fwd = a0[2:1] == 2'h1;
  wire       s_fwd = a1[2:1] == 2'h0 || a1 == 3'h3;
  sequence answered(dn, d, r);
    !dn && (d ^ r);
  endsequence
  sequence quiet(dn, d, r);
    dn && !d && !r;
  endsequence
  chk_pri_claim: assert property (cyc_start[0] && p_fwd && primary_other_devsel_n
    |=> answered(primary_device_select_n, resp_done[0], resp_retry[0]))
    else $error("primary cycle to secondary not claimed");
  chk_pri_local: assert property (cyc_start[0] && p_loc
    |=> quiet(primary_device_select_n, resp_done[0], resp_retry[0]))
    else $error("primary local cycle claimed");
  chk_pri_other: assert property (cyc_start[0] && !primary_other_devsel_n
    |=> quiet(primary_device_select_n, resp_done[0], resp_retry[0]))
    else $error("cycle claimed by another device answered");
  chk_pri_nowhere: assert property (cyc_start[0] && a0[2]
    |=> quiet(primary_device_select_n, resp_done[0], resp_retry[0]))
    else $error("undecoded primary cycle answered");
  chk_sec_same: assert property (cyc_start[1] && !s_fwd
    |=> quiet(secondary_one_device_select_n, resp_done[1], resp_retry[1]))
    else $error("secondary cycle without destination answered");
  chk_sec_claim: assert property (cyc_start[1] && s_fwd
    |=> answered(secondary_one_device_select_n, resp_done[1], resp_retry[1]))
    else $error("secondary cycle to other bus not claimed");
  chk_one_forward: assert property ($onehot0(~mst_frame_n))
    else $error("two forwarded cycles at once");
  for (genvar i = 0; i < 3; i++)
  begin : bus
    sequence no_target;
      ($fell(mst_frame_n[i]) && mst_devsel_n[i]) ##1 (mst_devsel_n[i] && !mst_ack[i])[*4];
    endsequence
    chk_abort_wait: assert property (no_target |=> mst_frame_n[i] && !mst_irdy_n[i])
      else $error("master abort frame release wrong");
    chk_abort_order: assert property ($rose(mst_frame_n[i]) && !mst_irdy_n[i]
      |=> mst_irdy_n[i])
      else $error("initiator ready not released after frame");
  end
endmodule
bind three_port_forwarding fwd_chk chk_u (.*);
`default_nettype wire

// ==== three_port_forwarding_test.sv ====
// Self-checking bench for the forwarding core
`timescale 1ns/100ps
`default_nettype none
`include "bridge_fwd_defs.vh"
module three_port_forwarding_test;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam [2:0] DONE = 3'h1, RETRY = 3'h2, NONE = 3'h4;
  localparam [3:0] RD = 4'h6, IOW = 4'h3;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [2:0]  cyc_start = 3'h0;
  logic [95:0] cyc_addr = 96'h0;
  logic [11:0] cyc_cmd = 12'h0;
  logic [95:0] cyc_wdata = 96'h0;
  logic        primary_other_devsel_n = 1'b1;
  logic [2:0]  silent = 3'h0;
  logic        stall = 1'b0;
  wire         primary_device_select_n, secondary_one_device_select_n;
  wire         secondary_two_device_select_n;
  wire  [2:0]  resp_done, resp_retry, mst_frame_n, mst_irdy_n, mst_devsel_n, mst_ack;
  wire  [31:0] resp_rdata, mst_addr, mst_wdata, mst_rdata;
  wire  [3:0]  mst_cmd;
  wire  [2:0]  dsel_n = {secondary_two_device_select_n, secondary_one_device_select_n,
                         primary_device_select_n};
  logic [69:0] fwd_q[$];
  int          num_errors = 0;
  int          n_compared = 0;
  int          cycles = 0;
  three_port_forwarding dut_u (.*);
  bus_targets far_u (.*);
  always #5 clk = ~clk;
  // Log every forwarded cycle that a target finished; cut a hang short
  always @(posedge clk)
  begin
    cycles++;
    for (int i = 0; i < 3; i++)
      if (mst_ack[i] && !mst_frame_n[i])
        fwd_q.push_back({i[1:0], mst_cmd, mst_addr, mst_wdata});
    if (cycles == 20000)
    begin
      num_errors++;
      end_of_test();
    end
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [69:0] got, input logic [69:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Answer is {select_n, retry, done}; an expectation of zero is not judged
  task automatic issue(input int p, input logic [31:0] a, input logic [3:0] c,
    input logic [31:0] d, input logic o, input logic [2:0] exp, output logic [2:0] ans);
    @(posedge clk);
    cyc_start[p] <= 1'b1;
    cyc_addr[p*32+:32] <= a;
    cyc_cmd[p*4+:4] <= c;
    cyc_wdata[p*32+:32] <= d;
    primary_other_devsel_n <= o;
    @(posedge clk);
    cyc_start <= 3'h0;
    primary_other_devsel_n <= 1'b1;
    #1;
    ans = {dsel_n[p], resp_retry[p], resp_done[p]};
    if (exp !== 3'h0)
      check(ans, exp);
  endtask
  task automatic wait_fwd(input int n);
    for (int k = 0; k < 300 && fwd_q.size() < n; k++)
      @(posedge clk);
    check(fwd_q.size(), n);
  endtask
  // Repeat a delayed cycle until it finishes, then judge its read data
  task automatic settle(input int p, input logic [31:0] a, input logic [3:0] c,
    input logic [31:0] r);
    logic [2:0] ans;
    ans = RETRY;
    for (int k = 0; k < 30 && ans === RETRY; k++)
      issue(p, a, c, 32'h0, 1'b1, 3'h0, ans);
    check(ans, DONE);
    if (!c[`CMD_WR_BIT])
      check(resp_rdata, r);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic s_decode();
    logic [2:0] ans;
    issue(0, 32'h10000000, RD, 0, 1'b1, NONE, ans);
    issue(0, 32'h40000000, RD, 0, 1'b0, NONE, ans);
    issue(0, 32'h80000000, RD, 0, 1'b1, NONE, ans);
    issue(1, 32'h48000000, RD, 0, 1'b1, NONE, ans);
    issue(2, 32'h90000000, RD, 0, 1'b1, NONE, ans);
    repeat (12) @(posedge clk);
    check(fwd_q.size(), 0);
  endtask
  task automatic s_posted();
    logic [69:0] exp[4];
    logic [2:0]  ans;
    fwd_q.delete();
    for (int k = 0; k < 4; k++)
    begin
      exp[k] = {k == 3 ? 2'd2 : 2'd0, k[0] ? `CMD_MEM_WR_INV : `CMD_MEM_WR,
                k == 3 ? 32'h60000000 : 32'(32'h100 + k * 4), 32'(32'hc0de0000 + k)};
      issue(k == 3 ? 0 : (k == 1 ? 2 : 1), exp[k][63:32], exp[k][67:64], exp[k][31:0],
            1'b1, DONE, ans);
    end
    wait_fwd(4);
    for (int k = 0; k < 4; k++)
      check(fwd_q[k], exp[k]);
  endtask
  // Stalled target: fill the queue until it refuses, then drain in order
  task automatic s_fill();
    logic [2:0] ans;
    int         acc;
    acc = 0;
    fwd_q.delete();
    @(posedge clk);
    stall <= 1'b1;
    for (int k = 0; k < 18; k++)
    begin
      issue(0, 32'(32'h40000000 + k * 4), `CMD_MEM_WR, 32'(k), 1'b1,
            k < 16 ? DONE : (k == 17 ? RETRY : 3'h0), ans);
      acc += int'(ans === DONE);
    end
    check(acc == 16 || acc == 17, 1);
    stall <= 1'b0;
    wait_fwd(acc);
    for (int k = 0; k < acc; k++)
      check(fwd_q[k], {2'd1, `CMD_MEM_WR, 32'(32'h40000000 + k * 4), 32'(k)});
  endtask
  task automatic s_read();
    logic [2:0] ans;
    fwd_q.delete();
    @(posedge clk);
    stall <= 1'b1;
    issue(2, 32'h50000000, `CMD_MEM_WR, 32'h5a5a0001, 1'b1, DONE, ans);
    issue(0, 32'h50000010, RD, 0, 1'b1, RETRY, ans);
    issue(0, 32'h50000010, RD, 0, 1'b1, RETRY, ans);
    stall <= 1'b0;
    wait_fwd(2);
    check(fwd_q[0], {2'd1, `CMD_MEM_WR, 32'h50000000, 32'h5a5a0001});
    check(fwd_q[1][69:32], {2'd1, RD, 32'h50000010});
    settle(0, 32'h50000010, RD, 32'hafffffef);
  endtask
  task automatic s_dwrite();
    logic [2:0] ans;
    fwd_q.delete();
    issue(1, 32'h60000020, IOW, 32'h11223344, 1'b1, RETRY, ans);
    wait_fwd(1);
    check(fwd_q[0], {2'd2, IOW, 32'h60000020, 32'h11223344});
    settle(1, 32'h60000020, IOW, 32'h0);
  endtask
  task automatic s_abort();
    logic [2:0] ans;
    fwd_q.delete();
    @(posedge clk);
    silent <= 3'h4;
    issue(0, 32'h60000040, RD, 0, 1'b1, RETRY, ans);
    settle(0, 32'h60000040, RD, `ABORT_RDATA);
    check(fwd_q.size(), 0);
    silent <= 3'h0;
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    s_decode();
    s_posted();
    s_fill();
    s_read();
    s_dwrite();
    s_abort();
    end_of_test();
  end
endmodule
`default_nettype wire
